// >>> rtl/slm_pkg.sv
// slm_pkg: register map, field layouts, mode codes and carriers of the lane mapper
// assumes: compiled before every module that names slm_pkg
package slm_pkg;
    localparam int LANES = 8;
    localparam int SMP_W = 12;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    // link modes handled here
    localparam logic [3:0] MODE_10B_8B10B = 4'hd;
    localparam logic [3:0] MODE_12B_PAIR = 4'he;
    localparam logic [3:0] MODE_12B_FOUR = 4'hf;
    // test pattern codes
    localparam logic [2:0] TEST_NONE = 3'h0;
    localparam logic [2:0] TEST_PRBS7 = 3'h1;
    localparam logic [2:0] TEST_PRBS9 = 3'h2;
    localparam logic [2:0] TEST_PRBS15 = 3'h3;
    localparam logic [2:0] TEST_PRBS23 = 3'h4;
    localparam logic [2:0] TEST_PRBS31 = 3'h5;
    localparam logic [2:0] TEST_CLOCK = 3'h6;
    // sample beats per frame and bits per lane frame
    localparam logic [4:0] BEATS_10B = 5'h10;
    localparam logic [4:0] BEATS_PAIR = 5'h04;
    localparam logic [4:0] BEATS_FOUR = 5'h08;
    localparam logic [5:0] FRAME_10B = 6'h28;
    localparam logic [5:0] FRAME_12B = 6'h18;
    // prbs feedback taps, in bits back
    localparam logic [4:0] P7_A = 5'h06;
    localparam logic [4:0] P7_B = 5'h07;
    localparam logic [4:0] P9_A = 5'h05;
    localparam logic [4:0] P9_B = 5'h09;
    localparam logic [4:0] P15_A = 5'h0e;
    localparam logic [4:0] P15_B = 5'h0f;
    localparam logic [4:0] P23_A = 5'h12;
    localparam logic [4:0] P23_B = 5'h17;
    localparam logic [4:0] P31_A = 5'h1c;
    localparam logic [4:0] P31_B = 5'h1f;
    // clock pattern: ones while the 16-step counter is below this
    localparam logic [3:0] CLK_ONES = 4'h8;
    localparam logic [5:0] STEADY_MAX = 6'h3f;
    typedef struct packed {
        logic pd_mode;
        logic link_en;
        logic narrow;
        logic fec_sel;
        logic alt_sel;
        logic [2:0] test_sel;
        logic [3:0] mode;
    } slm_ctrl_s;
    typedef struct packed {
        logic [7:0] lane_en;
        logic rsv;
        logic [2:0] test;
        logic mode_ok;
        logic alt_refused;
        logic alt_on;
        logic pd;
    } slm_status_s;
    typedef struct packed {
        logic [11:0] ch_d;
        logic [11:0] ch_c;
        logic [11:0] ch_b;
        logic [11:0] ch_a;
    } slm_beat_s;
endpackage : slm_pkg

// >>> rtl/slm_lane_tx.sv
// slm_lane_tx: sample fifo, lane mapper, test patterns and lane driver gating
// assumes: one clock, classic wishbone master, powerdown pin asynchronous
// How it works
// - 10-bit mode, A on lanes k mod 4
// - 12-bit pair mode, two lanes per channel
// - 12-bit four-lane mode, A lane k mod 4
// - selectable crc or fec sync-header scheme
// - crc is 12-bit only, no 3-bit
// - redundancy only in four-lane configurations
// - alternate select picks exactly one lane group
// - powerdown high disables all lane drivers
// - powerdown exit restarts link, flushes stale data
// - settings survive powerdown
// - test select picks pattern, lanes follow mode
// - prbs bypasses mapping, no encoding
// - prbs7 taps six and seven back
// - prbs9 and prbs15 taps
// - prbs23 and prbs31 taps
// - each lane starts prbs at own phase
// - clock pattern eight ones, eight zeros
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module slm_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : slm_fifo

module slm_lane_tx #(
    parameter int FIFO_DEPTH = slm_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic powerdown_input_i,
    input wire logic smp_valid_i,
    output logic smp_ready_o,
    input wire slm_pkg::slm_beat_s smp_data_i,
    output logic [7:0] lane_data_o,
    output logic [7:0] lane_drv_en_o,
    output logic crc12_en_o,
    output logic fec_en_o
);
    slm_pkg::slm_ctrl_s ctrl;
    slm_pkg::slm_status_s status;
    slm_pkg::slm_beat_s f_data;
    logic ack;
    logic wb_hit;
    logic wb_wr;
    logic wr_ctrl;
    logic pd_s1;
    logic pd_s2;
    logic pd_s3;
    logic pd_pin;
    logic pd;
    logic run;
    logic mode_ok;
    logic is10;
    logic alt_on;
    logic [2:0] act_test;
    logic f_valid;
    logic f_ready;
    logic pop;
    logic last;
    logic load;
    logic frame_full;
    logic [3:0] beat;
    logic [5:0] bitcnt;
    logic [3:0] pcnt;
    logic [4:0] tap_a;
    logic [4:0] tap_b;
    logic [39:0] gbuf [8];
    logic [39:0] shreg [8];
    logic [30:0] lfsr [8];
    logic [7:0] prbs_new;
    logic [7:0] base_bit;
    logic [7:0] routed;
    logic [7:0] next_en;

    function automatic logic [4:0] frame_beats(input logic [3:0] mode);
        if (mode == slm_pkg::MODE_10B_8B10B)
            frame_beats = slm_pkg::BEATS_10B;
        else if (mode == slm_pkg::MODE_12B_PAIR)
            frame_beats = slm_pkg::BEATS_PAIR;
        else
            frame_beats = slm_pkg::BEATS_FOUR;
    endfunction : frame_beats

    // which lanes a beat feeds: pair mode splits even/odd, else k mod 4
    function automatic logic lane_hit(input logic [3:0] mode, input logic [2:0] lane, input logic [3:0] k);
        if (mode == slm_pkg::MODE_12B_PAIR)
            lane_hit = (k[0] == lane[0]);
        else
            lane_hit = (k[1:0] == lane[1:0]);
    endfunction : lane_hit

    function automatic logic [11:0] lane_smp(input logic [3:0] mode, input logic [2:0] lane,
                                             input slm_pkg::slm_beat_s b);
        logic [1:0] ch;
        ch = (mode == slm_pkg::MODE_12B_PAIR) ? lane[2:1] : {1'b0, lane[2]};
        unique case (ch)
            2'h0: lane_smp = b.ch_a;
            2'h1: lane_smp = b.ch_b;
            2'h2: lane_smp = b.ch_c;
            2'h3: lane_smp = b.ch_d;
        endcase
    endfunction : lane_smp

    // register bus: one wait state, write lands on the acked edge
    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack;
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack;
    assign wr_ctrl = wb_wr & (wb_adr_i == slm_pkg::REG_CTRL);
    assign wb_ack_o = ack;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= wb_hit;
    end

    // control kept through powerdown, cleared only by rst_i
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl <= slm_pkg::CTRL_RESET;
        else if (wr_ctrl)
        begin
            if (wb_sel_i[0])
                ctrl[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl[11:8] <= wb_dat_i[11:8];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0;
        else if (wb_hit)
        begin
            if (wb_adr_i == slm_pkg::REG_CTRL)
                wb_dat_o <= {20'h0, ctrl};
            else if (wb_adr_i == slm_pkg::REG_STATUS)
                wb_dat_o <= {16'h0, status};
            else
                wb_dat_o <= 32'h0;
        end
    end

    // powerdown pin: three stages, taken when stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
            pd_s3 <= 1'b0;
            pd_pin <= 1'b0;
        end
        else
        begin
            pd_s1 <= powerdown_input_i;
            pd_s2 <= pd_s1;
            pd_s3 <= pd_s2;
            if (pd_s2 == pd_s3)
                pd_pin <= pd_s3;
        end
    end

    assign pd = pd_pin | ctrl.pd_mode;
    assign run = ctrl.link_en & ~pd;
    assign mode_ok = (ctrl.mode == slm_pkg::MODE_10B_8B10B) || (ctrl.mode == slm_pkg::MODE_12B_PAIR)
                     || (ctrl.mode == slm_pkg::MODE_12B_FOUR);
    assign is10 = (ctrl.mode == slm_pkg::MODE_10B_8B10B);
    assign alt_on = ctrl.alt_sel & ctrl.narrow;

    // sync-header scheme only in 64b/66b modes; crc is always the 12-bit one
    assign crc12_en_o = run & mode_ok & ~is10 & ~ctrl.fec_sel;
    assign fec_en_o = run & mode_ok & ~is10 & ctrl.fec_sel;

    // pattern choice only follows the field while the link is off
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act_test <= slm_pkg::TEST_NONE;
        else if (!ctrl.link_en)
            act_test <= ctrl.test_sel;
    end

    always_comb
    begin
        unique case (act_test)
            slm_pkg::TEST_PRBS9: {tap_a, tap_b} = {slm_pkg::P9_A, slm_pkg::P9_B};
            slm_pkg::TEST_PRBS15: {tap_a, tap_b} = {slm_pkg::P15_A, slm_pkg::P15_B};
            slm_pkg::TEST_PRBS23: {tap_a, tap_b} = {slm_pkg::P23_A, slm_pkg::P23_B};
            slm_pkg::TEST_PRBS31: {tap_a, tap_b} = {slm_pkg::P31_A, slm_pkg::P31_B};
            default: {tap_a, tap_b} = {slm_pkg::P7_A, slm_pkg::P7_B};
        endcase
    end

    // stale samples are dropped on powerdown
    slm_fifo #(
        .WIDTH($bits(slm_pkg::slm_beat_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(pd),
        .in_valid_i(smp_valid_i),
        .in_ready_o(smp_ready_o),
        .in_data_i(smp_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    assign f_ready = run & mode_ok & ~frame_full;
    assign pop = f_valid & f_ready;
    assign last = ({1'b0, beat} == frame_beats(ctrl.mode) - 5'h01);
    assign load = run & frame_full & (bitcnt <= 6'h01);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run)
        begin
            beat <= 4'h0;
            frame_full <= 1'b0;
        end
        else
        begin
            if (load)
                frame_full <= 1'b0;
            if (pop)
            begin
                beat <= last ? 4'h0 : beat + 4'h1;
                if (last)
                    frame_full <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run)
            bitcnt <= 6'h00;
        else if (load)
            bitcnt <= is10 ? slm_pkg::FRAME_10B : slm_pkg::FRAME_12B;
        else if (bitcnt != 6'h00)
            bitcnt <= bitcnt - 6'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run)
            pcnt <= 4'h0;
        else
            pcnt <= pcnt + 4'h1;
    end

    for (genvar l = 0; l < slm_pkg::LANES; l++)
    begin : g_lane
        localparam logic [2:0] LID = 3'(l);
        logic [11:0] smp;
        assign smp = lane_smp(ctrl.mode, LID, f_data);

        // samples shifted in msb first, in arrival order
        always_ff @(posedge clk_i)
        begin
            if (pop && lane_hit(ctrl.mode, LID, beat))
            begin
                if (is10)
                    gbuf[l] <= {gbuf[l][29:0], smp[11:2]};
                else
                    gbuf[l] <= {gbuf[l][27:0], smp};
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i || !run)
                shreg[l] <= 40'h0;
            else if (load)
                shreg[l] <= is10 ? gbuf[l] : {gbuf[l][23:0], 16'h0};
            else if (bitcnt != 6'h00)
                shreg[l] <= {shreg[l][38:0], 1'b0};
        end

        // seed differs per lane so every lane runs at its own phase
        always_ff @(posedge clk_i)
        begin
            if (rst_i || !run)
                lfsr[l] <= 31'(l + 1);
            else
                lfsr[l] <= {lfsr[l][29:0], prbs_new[l]};
        end

        assign prbs_new[l] = lfsr[l][tap_a - 5'h01] ^ lfsr[l][tap_b - 5'h01];

        always_comb
        begin
            unique case (act_test)
                slm_pkg::TEST_NONE: base_bit[l] = shreg[l][39] & (bitcnt != 6'h00);
                slm_pkg::TEST_CLOCK: base_bit[l] = (pcnt < slm_pkg::CLK_ONES);
                slm_pkg::TEST_PRBS7, slm_pkg::TEST_PRBS9, slm_pkg::TEST_PRBS15,
                slm_pkg::TEST_PRBS23, slm_pkg::TEST_PRBS31: base_bit[l] = prbs_new[l];
                default: base_bit[l] = 1'b0;
            endcase
        end
    end

    // alternate group carries the lower group's data
    assign routed = alt_on ? {base_bit[3:0], 4'h0} : base_bit;
    assign next_en = {{4{run & mode_ok & (~ctrl.narrow | alt_on)}}, {4{run & mode_ok & ~alt_on}}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lane_data_o <= 8'h00;
            lane_drv_en_o <= 8'h00;
        end
        else
        begin
            lane_data_o <= routed & next_en;
            lane_drv_en_o <= next_en;
        end
    end

    assign status.lane_en = lane_drv_en_o;
    assign status.rsv = 1'b0;
    assign status.test = act_test;
    assign status.mode_ok = mode_ok;
    assign status.alt_refused = ctrl.alt_sel & ~ctrl.narrow;
    assign status.alt_on = alt_on;
    assign status.pd = pd;

    // checking helpers
    logic [5:0] stdy;
    logic pop_q;
    logic [1:0] k_q;
    logic [11:0] a_q;
    logic prbs_on;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run || wr_ctrl)
            stdy <= 6'h00;
        else if (stdy != slm_pkg::STEADY_MAX)
            stdy <= stdy + 6'h01;
    end

    always_ff @(posedge clk_i)
    begin
        pop_q <= pop & ~rst_i;
        k_q <= beat[1:0];
        a_q <= f_data.ch_a;
    end

    assign prbs_on = (act_test != slm_pkg::TEST_NONE) && (act_test != slm_pkg::TEST_CLOCK);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    map_10b_a: assert property (pop_q && is10 |-> gbuf[k_q][9:0] == a_q[11:2])
        else $error("10-bit sample on wrong lane");
    map_pair_a: assert property (pop_q && ctrl.mode == slm_pkg::MODE_12B_PAIR
        |-> gbuf[{2'b00, k_q[0]}][11:0] == a_q)
        else $error("pair mode sample on wrong lane");
    map_four_a: assert property (pop_q && ctrl.mode == slm_pkg::MODE_12B_FOUR
        |-> gbuf[k_q][11:0] == a_q)
        else $error("12-bit sample on wrong lane");
    scheme_excl_a: assert property (fec_en_o |-> !crc12_en_o && !is10)
        else $error("both sync-header schemes on");
    alt_refuse_a: assert property (run && mode_ok && ctrl.alt_sel && !ctrl.narrow
        |=> lane_drv_en_o == 8'hff)
        else $error("alternate lanes taken in wide mode");
    one_group_a: assert property (ctrl.narrow |=> !(|lane_drv_en_o[3:0] && |lane_drv_en_o[7:4]))
        else $error("both lane groups active");
    pd_pin_off_a: assert property (powerdown_input_i [*5] |=> lane_drv_en_o == 8'h00)
        else $error("drivers on during powerdown");
    pd_flush_a: assert property (pd |=> !frame_full && beat == 4'h0 && !f_valid)
        else $error("stale frame kept over powerdown");
    pd_keep_a: assert property (pd && !wr_ctrl |=> $stable(ctrl))
        else $error("settings lost in powerdown");
    test_hold_a: assert property (ctrl.link_en |=> $stable(act_test))
        else $error("pattern changed with link on");
    lane_count_a: assert property (run && mode_ok && !ctrl.narrow |=> lane_drv_en_o == 8'hff)
        else $error("lane count not from link mode");
    prbs7_seq_a: assert property (stdy == slm_pkg::STEADY_MAX && act_test == slm_pkg::TEST_PRBS7
        && lane_drv_en_o[0] |-> lane_data_o[0] == ($past(lane_data_o[0], 6) ^ $past(lane_data_o[0], 7)))
        else $error("prbs7 recursion broken");
    prbs9_seq_a: assert property (stdy == slm_pkg::STEADY_MAX && act_test == slm_pkg::TEST_PRBS9
        && lane_drv_en_o[0] |-> lane_data_o[0] == ($past(lane_data_o[0], 5) ^ $past(lane_data_o[0], 9)))
        else $error("prbs9 recursion broken");
    prbs23_seq_a: assert property (stdy == slm_pkg::STEADY_MAX && act_test == slm_pkg::TEST_PRBS23
        && lane_drv_en_o[0] |-> lane_data_o[0] == ($past(lane_data_o[0], 18) ^ $past(lane_data_o[0], 23)))
        else $error("prbs23 recursion broken");
    prbs_phase_a: assert property (run && prbs_on |-> lfsr[0] != lfsr[1])
        else $error("lanes share prbs phase");
    clk_pat_a: assert property (stdy == slm_pkg::STEADY_MAX && act_test == slm_pkg::TEST_CLOCK
        && lane_drv_en_o[0] |-> lane_data_o[0] != $past(lane_data_o[0], 8))
        else $error("clock pattern half period wrong");
endmodule : slm_lane_tx

// >>> tb/slm_rx_model.sv
// slm_rx_model: link receiver, records lane bits and checks the prbs recurrence
// assumes: lane bits sampled on the rising edge of clk_i
`timescale 1ns/1ns
module slm_rx_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] lane_data_i,
    input wire logic [7:0] lane_drv_en_i,
    input wire logic [4:0] tap_a_i,
    input wire logic [4:0] tap_b_i,
    output logic [7:0][127:0] hist_o,
    output int prbs_err_o,
    output int prbs_chk_o
);
    int run [8];
    always_ff @(posedge clk_i)
    begin : b_judge
        int e;
        int c;
        e = prbs_err_o;
        c = prbs_chk_o;
        for (int l = 0; l < 8; l++)
        begin
            hist_o[l] <= {hist_o[l][126:0], lane_data_i[l]};
            // an idle or powered-down lane restarts its run count; its bits still go into hist_o
            run[l] <= (rst_i || !lane_drv_en_i[l]) ? 0 : run[l] + 1;
            // self-synchronise: judge only once tap_b bits are known
            if (!rst_i && tap_b_i != 5'h00 && run[l] >= int'(tap_b_i))
            begin
                c = c + 1;
                if (lane_data_i[l] !== (hist_o[l][tap_a_i - 1] ^ hist_o[l][tap_b_i - 1]))
                    e = e + 1;
            end
        end
        // counters start from zero so the bench can take differences
        prbs_err_o <= rst_i ? 0 : e;
        prbs_chk_o <= rst_i ? 0 : c;
    end
endmodule : slm_rx_model

// >>> tb/slm_lane_tx_tb.sv
// slm_lane_tx_tb: register, mapping, test pattern and powerdown scenarios
// assumes: slm_pkg, slm_lane_tx and slm_rx_model compiled first
`timescale 1ns/1ns
module slm_lane_tx_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pwr_dn = 0, sv = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    slm_pkg::slm_beat_s beat = '0;
    logic [7:0] ld, den;
    logic ack, rdy, crc, fec;
    logic [4:0] ta = 5'h00, tap_b = 5'h00;
    logic [7:0][127:0] h;
    int pe, pc, n_errors = 0, total_checks = 0;
    slm_lane_tx uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .powerdown_input_i(pwr_dn), .smp_valid_i(sv), .smp_ready_o(rdy), .smp_data_i(beat),
        .lane_data_o(ld), .lane_drv_en_o(den), .crc12_en_o(crc), .fec_en_o(fec));
    slm_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .lane_data_i(ld), .lane_drv_en_i(den),
        .tap_a_i(ta), .tap_b_i(tap_b), .hist_o(h), .prbs_err_o(pe), .prbs_chk_o(pc));
    initial forever #4 clk_i = ~clk_i;
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tmo(input int i);
        if (i >= 200)
        begin
            chk(32'h0, 32'h1, "wait expired");
            print_verdict();
        end
    endtask : tmo
    function automatic logic [31:0] cw(logic [3:0] m, logic [2:0] t, logic al, logic f, logic n, logic en);
        return {21'h0, en, n, f, al, t, m};
    endfunction : cw
    function automatic logic [11:0] smp(int c, int k);
        return 12'(12'ha53 ^ (c * 12'h111) ^ (k * 12'h09d));
    endfunction : smp
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (ack !== 1'b1 && i < 200);
        tmo(i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wait_den(input logic [7:0] e);
        int i;
        for (i = 0; i < 40 && den !== e; i++)
            @(posedge clk_i);
        chk(den, e, "lane enables");
    endtask : wait_den
    task automatic push(input int k);
        int i;
        beat <= '{ch_d: smp(3, k), ch_c: smp(2, k), ch_b: smp(1, k), ch_a: smp(0, k)};
        sv <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (rdy !== 1'b1 && i < 200);
        tmo(i);
    endtask : push
    task automatic reg_test;
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0, "ctrl reset");
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0, "status reset");
        wb(1'b1, 4'h8, 32'hffff_ffff);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0, "unmapped read");
        wb(1'b1, 4'h0, 32'hffff_f0ff);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0000_00ff, "ctrl width");
        wb(1'b1, 4'h0, 32'h0);
    endtask : reg_test
    task automatic crc_test;
        wb(1'b1, 4'h0, cw(4'he, 3'h0, 0, 0, 0, 1));
        @(posedge clk_i);
        chk({crc, fec}, 2'b10, "crc12 scheme");
        wb(1'b1, 4'h0, cw(4'he, 3'h0, 0, 1, 0, 1));
        @(posedge clk_i);
        chk({crc, fec}, 2'b01, "fec scheme");
        wb(1'b1, 4'h0, cw(4'hd, 3'h0, 0, 0, 0, 1));
        @(posedge clk_i);
        chk({crc, fec}, 2'b00, "8b10b no header");
        wb(1'b1, 4'h0, 32'h0);
    endtask : crc_test
    task automatic alt_test;
        logic [1:0] na [3] = '{2'b10, 2'b11, 2'b01};
        logic [7:0] ex [3] = '{8'h0f, 8'hf0, 8'hff};
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, 4'h0, cw(4'hf, 3'h0, na[i][0], 0, na[i][1], 1));
            wait_den(ex[i]);
            wb(1'b0, 4'h4, 32'h0);
            chk(q[2], i == 2, "alt refused");
        end
        wb(1'b1, 4'h0, 32'h0);
    endtask : alt_test
    task automatic sleep_test;
        wb(1'b1, 4'h0, cw(4'hf, 3'h0, 0, 0, 0, 1));
        wait_den(8'hff);
        pwr_dn <= 1'b1;
        wait_den(8'h00);
        chk(ld, 8'h00, "lanes quiet");
        wb(1'b0, 4'h0, 32'h0);
        chk(q, cw(4'hf, 3'h0, 0, 0, 0, 1), "ctrl kept");
        pwr_dn <= 1'b0;
        wait_den(8'hff);
        wb(1'b1, 4'h0, cw(4'hf, 3'h0, 0, 0, 0, 1) | 32'h800);
        wait_den(8'h00);
        wb(1'b1, 4'h0, 32'h0);
    endtask : sleep_test
    task automatic map_test(input logic [3:0] m, input int nb, input int st, input int cnt, input int w);
        logic [47:0] p;
        logic [47:0] msk;
        int ok;
        wb(1'b1, 4'h0, cw(m, 3'h0, 0, 0, 0, 0));
        for (int k = 0; k < 4; k++)
            push(k);
        sv <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(rdy, 1'b0, "fifo full");
        wb(1'b1, 4'h0, cw(m, 3'h0, 0, 0, 0, 1));
        for (int k = 4; k < nb; k++)
            push(k);
        sv <= 1'b0;
        repeat (60) @(posedge clk_i);
        for (int l = 0; l < 8; l++)
        begin
            p = '0;
            for (int j = 0; j < cnt; j++)
                p = (p << w) | (smp((st == 2) ? l / 2 : l / 4, l % st + j * st) >> (12 - w));
            msk = (48'h1 << (cnt * w)) - 48'h1;
            ok = 0;
            for (int i = 0; i + cnt * w <= 128; i++)
                if (((h[l] >> i) & {80'h0, msk}) === {80'h0, p})
                    ok = 1;
            chk(ok, 1, "lane frame");
        end
        chk(rdy, 1'b1, "fifo drained");
        wb(1'b1, 4'h0, 32'h0);
    endtask : map_test
    task automatic prbs_test(input logic [2:0] t, input logic [4:0] a, input logic [4:0] b);
        int e0, c0, same;
        ta <= a;
        tap_b <= b;
        wb(1'b1, 4'h0, cw(4'hf, t, 0, 0, 0, 0));
        e0 = pe;
        c0 = pc;
        wb(1'b1, 4'h0, cw(4'hf, t, 0, 0, 0, 1));
        repeat (100) @(posedge clk_i);
        wb(1'b0, 4'h4, 32'h0);
        chk(q[6:4], t, "active test");
        chk(q[15:8], 8'hff, "lanes follow mode");
        chk(pe - e0, 0, "prbs recurrence");
        chk(pc > c0, 1'b1, "prbs judged");
        same = 0;
        for (int l = 1; l < 8; l++)
            if (h[l][63:0] === h[0][63:0])
                same++;
        chk(same, 0, "lane phases");
        wb(1'b1, 4'h0, 32'h0);
    endtask : prbs_test
    task automatic clock_test;
        int bad, tr;
        ta <= 5'h00;
        tap_b <= 5'h00;
        wb(1'b1, 4'h0, cw(4'hf, slm_pkg::TEST_CLOCK, 0, 0, 0, 0));
        wb(1'b1, 4'h0, cw(4'hf, slm_pkg::TEST_CLOCK, 0, 0, 0, 1));
        repeat (60) @(posedge clk_i);
        bad = 0;
        tr = 0;
        for (int l = 0; l < 8; l++)
            for (int i = 0; i < 40; i++)
            begin
                if (h[l][i] === h[l][i + 8] || h[l][i] !== h[l][i + 16])
                    bad++;
                if (i < 16 && h[l][i] !== h[l][i + 1])
                    tr++;
            end
        chk(bad, 0, "clock period");
        chk(tr, 16, "clock runs of eight");
        wb(1'b1, 4'h0, 32'h0);
    endtask : clock_test
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_test();
        crc_test();
        alt_test();
        sleep_test();
        map_test(4'hd, 16, 4, 4, 10);
        map_test(4'he, 4, 2, 2, 12);
        map_test(4'hf, 8, 4, 2, 12);
        prbs_test(slm_pkg::TEST_PRBS7, slm_pkg::P7_A, slm_pkg::P7_B);
        prbs_test(slm_pkg::TEST_PRBS9, slm_pkg::P9_A, slm_pkg::P9_B);
        prbs_test(slm_pkg::TEST_PRBS15, slm_pkg::P15_A, slm_pkg::P15_B);
        prbs_test(slm_pkg::TEST_PRBS23, slm_pkg::P23_A, slm_pkg::P23_B);
        prbs_test(slm_pkg::TEST_PRBS31, slm_pkg::P31_A, slm_pkg::P31_B);
        clock_test();
        print_verdict();
    end
endmodule : slm_lane_tx_tb
